// ==== shared/rtcc_pkg.sv ====
// Shared constants for the real-time counter control block
package rtcc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADR_CTL_A    = 8'h00; // Control A
  localparam logic [7:0]  ADR_BUSY     = 8'h04; // Sync busy status
  localparam logic [7:0]  ADR_COUNT    = 8'h08; // Live count, read only
  localparam logic [7:0]  ADR_COMP     = 8'h0C; // Compare/alarm 0

  // ----------------------------------------------------------------
  // Control A fields and reset values
  // ----------------------------------------------------------------
  localparam int          F_SOFT_RST   = 0;        // Soft reset bit
  localparam int          F_EN         = 1;        // Enable bit
  localparam int          F_MODE       = 2;        // Mode field low bit
  localparam int          F_HIT_CLR    = 7;        // Clear on compare hit
  localparam int          F_PRESC      = 8;        // Prescaler field low bit
  localparam logic [15:0] CTL_A_RST    = 16'h0000; // Control A after reset
  localparam logic [15:0] CTL_A_WMASK  = 16'h0F8E; // Writable stored bits
  localparam logic [31:0] COMP_RST     = 32'h0000_0000;
  localparam int          B_SOFT_RST   = 0;        // Busy bit of soft reset
  localparam int          B_EN         = 1;        // Busy bit of enable

  // ----------------------------------------------------------------
  // Operating modes and prescaler codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RTCC_WIDE_COUNTER_MODE = 2'h0, // 32-bit counter
    RTCC_HALF_COUNTER_MODE = 2'h1, // 16-bit counter
    RTCC_CALENDAR_MODE     = 2'h2  // Clock/calendar
  } rtcc_mode_t;
  localparam logic [3:0]  PRESC_OFF    = 4'h0;  // No counting
  localparam logic [3:0]  PRESC_BY_512 = 4'hA;  // Divide by 512
  localparam logic [3:0]  PRESC_DIV1K  = 4'hB;  // Divide by 1024, top code
  localparam logic [5:0]  CAL_MIN_SEC  = 6'h3B; // Last second / minute
  localparam logic [4:0]  CAL_HOUR     = 5'h17; // Last hour
  localparam int          SYNC_STAGES  = 2;     // Flops per crossing
  localparam int          BUSY_MAX_CYC = 12;    // Longest busy window

endpackage

// ==== core/rtcc_count.sv ====
// Counter side: prescaler, counter modes, compare hit and command apply
`timescale 1ns/1ps

module rtcc_count (
  input  wire logic        clk_i,       // System clock
  input  wire logic        rst_i,       // Synchronous reset
  input  wire logic        src_clk_i,   // counter_source_clock, sampled
  input  wire logic        req_tgl_i,   // Command request toggle
  input  wire logic        cmd_en_i,    // Enable value of the command
  input  wire logic        cmd_rst_i,   // Command is a soft reset
  input  wire logic [1:0]  mode_i,      // Operating mode
  input  wire logic [3:0]  presc_i,     // Prescaler code
  input  wire logic        hit_clr_i,   // clear_on_compare_hit
  input  wire logic [31:0] comp_i,      // Compare value
  output logic             ack_tgl_o,   // Command done toggle
  output logic             enabled_o,   // Counter really enabled
  output logic [31:0]      count_o,     // Current count
  output logic             hit_o        // Compare hit pulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  req_s;    // Request synchroniser, bit 0 first
    logic        req_seen; // Last request toggle handled
    logic        ack_tgl;  // Done toggle
    logic        en;       // Counting enabled
    logic [31:0] cnt;      // Counter
    logic [9:0]  pre;      // Prescaler counter
    logic        src_prev; // Last source clock sample
    logic        hit;      // Hit pulse
  } rtcc_cnt_t;

  rtcc_cnt_t q, d;
  logic      rise;   // Source clock rising edge
  logic      tick;   // Divided count clock event
  logic      match;  // Count equals compare
  logic [9:0] mask;  // Prescaler terminal mask

  // Calendar increment: seconds, minutes, hours, then days
  function automatic logic [31:0] rtcc_cal_inc(input logic [31:0] c);
    logic [31:0] r;
    r = c;
    if (c[5:0] != rtcc_pkg::CAL_MIN_SEC) begin
      r[5:0] = c[5:0] + 6'h01;
    end else begin
      r[5:0] = 6'h00;
      if (c[11:6] != rtcc_pkg::CAL_MIN_SEC) begin
        r[11:6] = c[11:6] + 6'h01;
      end else begin
        r[11:6] = 6'h00;
        if (c[16:12] != rtcc_pkg::CAL_HOUR) begin
          r[16:12] = c[16:12] + 5'h01;
        end else begin
          r[16:12] = 5'h00;
          r[31:17] = c[31:17] + 15'h0001;
        end
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d          = q;
    d.hit      = 1'b0;
    d.req_s    = {q.req_s[0], req_tgl_i};
    d.src_prev = src_clk_i;
    rise       = src_clk_i & ~q.src_prev;
    // Code n ticks once the low n-1 prescaler bits are all ones; 0 and reserved codes stop
    mask       = 10'h3FF >> (rtcc_pkg::PRESC_DIV1K - presc_i);
    tick       = q.en && rise && (presc_i != rtcc_pkg::PRESC_OFF) &&
                 (presc_i <= rtcc_pkg::PRESC_DIV1K) && ((q.pre & mask) == mask);
    match      = (mode_i == rtcc_pkg::RTCC_HALF_COUNTER_MODE) ?
                 (q.cnt[15:0] == comp_i[15:0]) : (q.cnt == comp_i);
    if (q.en && rise) begin
      d.pre = q.pre + 10'h001;
    end
    if (tick) begin
      d.hit = match;
      if (match && hit_clr_i) begin
        d.cnt = 32'h0000_0000;
      end else begin
        unique case (mode_i)
          rtcc_pkg::RTCC_HALF_COUNTER_MODE: d.cnt = {16'h0000, q.cnt[15:0] + 16'h0001};
          rtcc_pkg::RTCC_CALENDAR_MODE:     d.cnt = rtcc_cal_inc(q.cnt);
          default:                          d.cnt = q.cnt + 32'h0000_0001;
        endcase
      end
    end
    // A soft reset command arriving overrides counting in the same cycle
    if (q.req_s[1] != q.req_seen) begin
      d.req_seen = q.req_s[1];
      d.ack_tgl  = ~q.ack_tgl;
      if (cmd_rst_i) begin
        d.en  = 1'b0;
        d.cnt = 32'h0000_0000;
        d.pre = 10'h000;
        d.hit = 1'b0;
      end else begin
        d.en  = cmd_en_i;
      end
    end
  end

  // Register the whole state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ack_tgl_o = q.ack_tgl;
  assign enabled_o = q.en;
  assign count_o   = q.cnt;
  assign hit_o     = q.hit;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_div1k;
    tick && presc_i == rtcc_pkg::PRESC_DIV1K |-> q.pre == 10'h3FF;
  endproperty
  a_div1k: assert property (p_div1k) else $error("divide by 1024 tick misplaced");

  property p_clr_hit;
    tick && match && hit_clr_i && (q.req_s[1] == q.req_seen) |=> q.cnt == 32'h0000_0000;
  endproperty
  a_clr_hit: assert property (p_clr_hit) else $error("count not cleared on hit");

  property p_no_clr;
    tick && match && !hit_clr_i && mode_i == rtcc_pkg::RTCC_WIDE_COUNTER_MODE &&
      (q.req_s[1] == q.req_seen) |=> q.cnt == $past(q.cnt) + 32'h0000_0001;
  endproperty
  a_no_clr: assert property (p_no_clr) else $error("count cleared without enable");

  property p_half;
    tick && mode_i == rtcc_pkg::RTCC_HALF_COUNTER_MODE |=> q.cnt[31:16] == 16'h0000;
  endproperty
  a_half: assert property (p_half) else $error("half mode upper bits set");

  c_hit: cover property (hit_o);

endmodule // rtcc_count

// ==== core/rtcc_ctrl.sv ====
// Top of the real-time counter control: Wishbone registers and sync logic
`timescale 1ns/1ps

// Notes on behaviour
// - Prescaler code picks divider; 0xC-0xF reserved
// - Clear-on-hit bit zeroes counter on compare hit
// - Mode: 32-bit, 16-bit, calendar; 3 reserved
// - Enable reads back at once, sets busy
// - Enable busy clears once counter really switched
// - Soft reset restores registers and disables
// - Soft reset write discards other fields
// - Soft reset bit self-clears when reset done
// - Soft reset bit reads one while ongoing
module rtcc_ctrl (
  input  wire logic        clk_i,     // System clock, 100 MHz
  input  wire logic        rst_i,     // Synchronous reset, active high
  input  wire logic        cyc_i,     // Wishbone cycle
  input  wire logic        stb_i,     // Wishbone strobe
  input  wire logic        we_i,      // Wishbone write enable
  input  wire logic [7:0]  adr_i,     // Wishbone byte address
  input  wire logic [3:0]  sel_i,     // Wishbone byte selects
  input  wire logic [31:0] dat_i,     // Wishbone write data
  input  wire logic        src_clk_i, // counter_source_clock level
  output logic [31:0]      dat_o,     // Wishbone read data
  output logic             ack_o,     // Wishbone acknowledge
  output logic             hit_o      // Compare hit pulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    RTCC_IDLE = 1'b0, // No command in flight
    RTCC_WAIT = 1'b1  // Waiting for the counter side
  } rtcc_sync_t;

  typedef struct packed {
    logic [15:0] ctrl;     // counter_control_a
    logic [31:0] comp;     // Compare value
    logic [1:0]  busy;     // sync_busy_status
    logic        req_tgl;  // Request toggle out
    logic        cmd_en;   // Enable value in flight
    logic        cmd_rst;  // Soft reset in flight
    logic [1:0]  ack_s;    // Done synchroniser, bit 0 first
    logic        ack_seen; // Last done toggle handled
    logic        ack;      // Bus acknowledge
    logic [31:0] rdat;     // Read data
    rtcc_sync_t  st;       // Sync state
  } rtcc_ctl_t;

  rtcc_ctl_t   q, d;
  logic        ack_tgl_w;  // Done toggle from counter side
  logic        enabled_w;  // Counter really enabled
  logic [31:0] count_w;    // Live count
  logic        acc;        // Bus access taken this cycle
  logic        done;       // Command completion seen
  logic [15:0] wv;         // Control A after byte merge
  logic        wr_ctrl;    // Control A write taken
  logic        wr_srst;    // Soft reset write taken

  // ----------------------------------------------------------------
  // Counter side
  // ----------------------------------------------------------------
  rtcc_count u_count (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .src_clk_i  (src_clk_i),
    .req_tgl_i  (q.req_tgl),
    .cmd_en_i   (q.cmd_en),
    .cmd_rst_i  (q.cmd_rst),
    .mode_i     (q.ctrl[rtcc_pkg::F_MODE +: 2]),
    .presc_i    (q.ctrl[rtcc_pkg::F_PRESC +: 4]),
    .hit_clr_i  (q.ctrl[rtcc_pkg::F_HIT_CLR]),
    .comp_i     (q.comp),
    .ack_tgl_o  (ack_tgl_w),
    .enabled_o  (enabled_w),
    .count_o    (count_w),
    .hit_o      (hit_o)
  );

  // ----------------------------------------------------------------
  // Next state: bus slave and command handshake
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    d.ack   = 1'b0;
    d.ack_s = {q.ack_s[0], ack_tgl_w};
    acc     = cyc_i && stb_i && !q.ack;
    done    = (q.st == RTCC_WAIT) && (q.ack_s[1] != q.ack_seen);
    // Byte lane merge into Control A
    wv      = q.ctrl;
    if (sel_i[0]) begin
      wv[7:0] = dat_i[7:0];
    end
    if (sel_i[1]) begin
      wv[15:8] = dat_i[15:8];
    end
    // Control A writes during a pending command are dropped to keep it stable
    wr_ctrl  = acc && we_i && (adr_i[7:2] == rtcc_pkg::ADR_CTL_A[7:2]) && (q.st == RTCC_IDLE);
    wr_srst  = wr_ctrl && wv[rtcc_pkg::F_SOFT_RST];

    // Completion of the counter-side command
    if (done) begin
      d.ack_seen = q.ack_s[1];
      d.busy     = 2'b00;
      d.st       = RTCC_IDLE;
      if (q.cmd_rst) begin
        d.ctrl[rtcc_pkg::F_SOFT_RST] = 1'b0;
      end
    end

    if (acc) begin
      d.ack = 1'b1;
      // Registered read data, unmapped reads as zero
      if (adr_i[7:2] == rtcc_pkg::ADR_CTL_A[7:2]) begin
        d.rdat = {16'h0000, q.ctrl};
      end else if (adr_i[7:2] == rtcc_pkg::ADR_BUSY[7:2]) begin
        d.rdat = {30'h0000_0000, q.busy};
      end else if (adr_i[7:2] == rtcc_pkg::ADR_COUNT[7:2]) begin
        d.rdat = count_w;
      end else if (adr_i[7:2] == rtcc_pkg::ADR_COMP[7:2]) begin
        d.rdat = q.comp;
      end else begin
        d.rdat = 32'h0000_0000;
      end
    end

    if (wr_srst) begin
      // Every other field of this write is thrown away
      d.ctrl    = rtcc_pkg::CTL_A_RST;
      d.ctrl[rtcc_pkg::F_SOFT_RST] = 1'b1;
      d.comp    = rtcc_pkg::COMP_RST;
      d.cmd_rst = 1'b1;
      d.cmd_en  = 1'b0;
      d.busy    = 2'b00;
      d.busy[rtcc_pkg::B_SOFT_RST] = 1'b1;
      d.req_tgl = ~q.req_tgl;
      d.st      = RTCC_WAIT;
    end else if (wr_ctrl) begin
      d.ctrl = wv & rtcc_pkg::CTL_A_WMASK;
      if (wv[rtcc_pkg::F_EN] != q.ctrl[rtcc_pkg::F_EN]) begin
        d.cmd_rst = 1'b0;
        d.cmd_en  = wv[rtcc_pkg::F_EN];
        d.busy    = 2'b00;
        d.busy[rtcc_pkg::B_EN] = 1'b1;
        d.req_tgl = ~q.req_tgl;
        d.st      = RTCC_WAIT;
      end
    end else if (acc && we_i && (adr_i[7:2] == rtcc_pkg::ADR_COMP[7:2])) begin
      // Compare needs no handshake, written per byte lane
      for (int i = 0; i < 4; i++) begin
        if (sel_i[i]) begin
          d.comp[8*i +: 8] = dat_i[8*i +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register the whole state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q      <= '0;
      q.ctrl <= rtcc_pkg::CTL_A_RST;
      q.comp <= rtcc_pkg::COMP_RST;
      q.st   <= RTCC_IDLE;
    end else begin
      q <= d;
    end
  end

  assign dat_o = q.rdat;
  assign ack_o = q.ack;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_en_rb;
    wr_ctrl && !wr_srst && sel_i[0] |=> q.ctrl[rtcc_pkg::F_EN] == $past(dat_i[rtcc_pkg::F_EN]);
  endproperty
  a_en_rb: assert property (p_en_rb) else $error("enable not read back");

  property p_en_busy;
    wr_ctrl && !wr_srst && (wv[rtcc_pkg::F_EN] != q.ctrl[rtcc_pkg::F_EN])
      |=> q.busy[rtcc_pkg::B_EN] && enabled_w != q.ctrl[rtcc_pkg::F_EN];
  endproperty
  a_en_busy: assert property (p_en_busy) else $error("enable busy not set");

  property p_en_done;
    $fell(q.busy[rtcc_pkg::B_EN]) |-> enabled_w == q.ctrl[rtcc_pkg::F_EN];
  endproperty
  a_en_done: assert property (p_en_done) else $error("busy cleared before switch");

  property p_busy_end;
    $rose(q.st) |-> ##[1:12] q.st == RTCC_IDLE;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("sync never completed");

  property p_rst_all;
    wr_srst |=> q.comp == rtcc_pkg::COMP_RST && !q.ctrl[rtcc_pkg::F_EN] ##[1:12] !enabled_w;
  endproperty
  a_rst_all: assert property (p_rst_all) else $error("soft reset left state");

  property p_rst_discard;
    wr_srst |=> q.ctrl == (rtcc_pkg::CTL_A_RST | 16'h0001);
  endproperty
  a_rst_discard: assert property (p_rst_discard) else $error("soft reset kept fields");

  property p_rst_clear;
    $fell(q.ctrl[rtcc_pkg::F_SOFT_RST]) |-> !enabled_w && count_w == 32'h0000_0000 &&
      !q.busy[rtcc_pkg::B_SOFT_RST];
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("soft reset cleared early");

  property p_rst_hold;
    wr_srst |=> q.ctrl[rtcc_pkg::F_SOFT_RST] [*4];
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("soft reset bit dropped");

  c_enable: cover property ($fell(q.busy[rtcc_pkg::B_EN]) && enabled_w);
  c_soft_rst: cover property ($fell(q.ctrl[rtcc_pkg::F_SOFT_RST]));

  // Single-cycle acknowledge; a strobe held past it is taken again every other cycle
  property p_ack_one;
    ack_o |=> !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("acknowledge held over two cycles");
  c_read:   cover property (acc && !we_i && adr_i[7:2] == rtcc_pkg::ADR_BUSY[7:2]);

endmodule // rtcc_ctrl

// ==== bench/rtcc_testbench.sv ====
// Self-checking bench for the real-time counter control block
`timescale 1ns/1ps

module testbench;
  // ------------------------------------------------------------
  // Bench signals
  // ------------------------------------------------------------
  logic        clk_i     = 1'b0;          // 100 MHz system clock
  logic        rst_i     = 1'b1;          // Synchronous reset, high
  logic        cyc_i     = 1'b0;          // Bus cycle
  logic        stb_i     = 1'b0;          // Bus strobe
  logic        we_i      = 1'b0;          // Write select
  logic [7:0]  adr_i     = 8'h00;         // Byte address
  logic [3:0]  sel_i     = 4'h0;          // Byte lanes
  logic [31:0] dat_i     = 32'h0000_0000; // Write data
  logic        src_clk_i = 1'b0;          // Counter source, a quarter of clk_i
  logic        src_div   = 1'b0;          // Halves the source toggle rate
  logic [31:0] dat_o;                     // Read data
  logic        ack_o;                     // Bus acknowledge
  logic        hit_o;                     // Compare hit pulse
  logic [31:0] rd;                        // Last word read
  int          errors    = 0;             // Mismatch count
  int          cmp_count = 0;             // Comparison count
  int          hit_cnt   = 0;             // Hit pulses seen

  // ------------------------------------------------------------
  // Clock, source clock and hit monitor
  // ------------------------------------------------------------
  always #5 clk_i = ~clk_i;

  // Source kept well under clk_i/2 so no rising edge is lost
  always @(posedge clk_i) begin
    src_div <= ~src_div;
    if (src_div) begin
      src_clk_i <= ~src_clk_i;
    end
    if (hit_o === 1'b1) begin
      hit_cnt <= hit_cnt + 1;
    end
  end

  rtcc_ctrl dut_u (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .cyc_i     (cyc_i),
    .stb_i     (stb_i),
    .we_i      (we_i),
    .adr_i     (adr_i),
    .sel_i     (sel_i),
    .dat_i     (dat_i),
    .src_clk_i (src_clk_i),
    .dat_o     (dat_o),
    .ack_o     (ack_o),
    .hit_o     (hit_o)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Builds a control word from its fields
  function automatic logic [31:0] ctl(logic en, logic [1:0] md, logic mc, logic [3:0] ps);
    ctl = ({31'h0, en} << rtcc_pkg::F_EN) | ({30'h0, md} << rtcc_pkg::F_MODE)
        | ({31'h0, mc} << rtcc_pkg::F_HIT_CLR) | ({28'h0, ps} << rtcc_pkg::F_PRESC);
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Classic single cycle; ack is read before this edge's updates land
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      errors++;
      print_verdict();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask

  task automatic rdw(input logic [7:0] a);
    wb(1'b0, a, 32'h0000_0000, 4'hF);
  endtask

  // Bounded poll until the masked bits read zero
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      rdw(a);
      n++;
    end while ((rd & m) !== 32'h0000_0000 && n < 30);
    check("poll clear", 32'h0000_0000, rd & m);
    // A poll that ran out of tries ends the run
    if ((rd & m) !== 32'h0000_0000) begin
      print_verdict();
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rdw(rtcc_pkg::ADR_CTL_A);
    check("control a reset", {16'h0000, rtcc_pkg::CTL_A_RST}, rd);
    rdw(rtcc_pkg::ADR_BUSY);
    check("busy reset", 32'h0000_0000, rd);
    rdw(rtcc_pkg::ADR_COMP);
    check("compare reset", rtcc_pkg::COMP_RST, rd);
    $display("test reset done");
  endtask

  task automatic t_fields;
    logic [31:0] v;
    for (int m = 0; m < 3; m++) begin
      for (int p = 10; p < 12; p++) begin
        v = ctl(1'b0, m[1:0], m[0], p[3:0]);
        wr(rtcc_pkg::ADR_CTL_A, v | 32'hFFFF_0070);
        rdw(rtcc_pkg::ADR_CTL_A);
        check("control a fields", v, rd);
      end
    end
    // Low lane only: prescaler byte keeps its old code
    wb(1'b1, rtcc_pkg::ADR_CTL_A, ctl(1'b0, 2'h1, 1'b1, 4'h0), 4'h1);
    rdw(rtcc_pkg::ADR_CTL_A);
    check("control a low lane", ctl(1'b0, 2'h1, 1'b1, 4'hB), rd);
    wr(8'h40, 32'hFFFF_FFFF);
    rdw(8'h40);
    check("unmapped read", 32'h0000_0000, rd);
    wr(rtcc_pkg::ADR_COUNT, 32'h0000_0005);
    rdw(rtcc_pkg::ADR_COUNT);
    check("count read only", 32'h0000_0000, rd);
    $display("test fields done");
  endtask

  task automatic t_match;
    int          h;
    logic [31:0] mx;
    wr(rtcc_pkg::ADR_COMP, 32'h0000_0003);
    wr(rtcc_pkg::ADR_CTL_A, ctl(1'b1, 2'h0, 1'b1, 4'h1));
    rdw(rtcc_pkg::ADR_BUSY);
    check("enable busy set", 32'h1 << rtcc_pkg::B_EN, rd);
    poll(rtcc_pkg::ADR_BUSY, 32'h1 << rtcc_pkg::B_EN);
    rdw(rtcc_pkg::ADR_CTL_A);
    check("enable readback", ctl(1'b1, 2'h0, 1'b1, 4'h1), rd);
    h  = hit_cnt;
    mx = 32'h0000_0000;
    repeat (12) begin
      idle(5);
      rdw(rtcc_pkg::ADR_COUNT);
      if (rd > mx) begin
        mx = rd;
      end
    end
    check("count held to compare", 32'h1, {31'h0, mx <= 32'h3});
    check("hit seen", 32'h1, {31'h0, hit_cnt > h});
    // Same enable value, so no handshake is needed here
    wr(rtcc_pkg::ADR_CTL_A, ctl(1'b1, 2'h0, 1'b0, 4'h1));
    idle(80);
    rdw(rtcc_pkg::ADR_COUNT);
    check("count runs past compare", 32'h1, {31'h0, rd > 32'h3});
    wr(rtcc_pkg::ADR_CTL_A, ctl(1'b0, 2'h0, 1'b0, 4'h1));
    poll(rtcc_pkg::ADR_BUSY, 32'h1 << rtcc_pkg::B_EN);
    rdw(rtcc_pkg::ADR_COUNT);
    mx = rd;
    idle(40);
    rdw(rtcc_pkg::ADR_COUNT);
    check("count stopped", mx, rd);
    $display("test match and enable done");
  endtask

  // Soft reset with other fields in the same write
  task automatic do_srst(input logic [31:0] extra);
    wr(rtcc_pkg::ADR_CTL_A, extra | 32'h0000_0001);
    rdw(rtcc_pkg::ADR_CTL_A);
    check("control a during soft reset", 32'h0000_0001, rd);
    rdw(rtcc_pkg::ADR_COMP);
    check("compare after soft reset", rtcc_pkg::COMP_RST, rd);
    poll(rtcc_pkg::ADR_CTL_A, 32'h0000_0001);
    rdw(rtcc_pkg::ADR_BUSY);
    check("busy after soft reset", 32'h0000_0000, rd);
    rdw(rtcc_pkg::ADR_COUNT);
    check("count after soft reset", 32'h0000_0000, rd);
  endtask

  task automatic t_soft_rst;
    wr(rtcc_pkg::ADR_COMP, 32'h0000_0100);
    wr(rtcc_pkg::ADR_CTL_A, ctl(1'b1, 2'h0, 1'b0, 4'h1));
    poll(rtcc_pkg::ADR_BUSY, 32'h1 << rtcc_pkg::B_EN);
    idle(40);
    do_srst(ctl(1'b1, 2'h2, 1'b1, 4'hA));
    idle(40);
    rdw(rtcc_pkg::ADR_COUNT);
    check("disabled after soft reset", 32'h0000_0000, rd);
    $display("test soft reset done");
  endtask

  // One source tick per 4 clocks: /512 ticks every 2048, /1024 every 4096
  task automatic presc_case(input logic [3:0] code, input logic [31:0] e1, input logic [31:0] e2);
    do_srst(32'h0000_0000);
    wr(rtcc_pkg::ADR_CTL_A, ctl(1'b1, 2'h0, 1'b0, code));
    poll(rtcc_pkg::ADR_BUSY, 32'h1 << rtcc_pkg::B_EN);
    idle(2500);
    rdw(rtcc_pkg::ADR_COUNT);
    check("divided count early", e1, rd);
    idle(2600);
    rdw(rtcc_pkg::ADR_COUNT);
    check("divided count late", e2, rd);
  endtask

  task automatic t_presc;
    presc_case(4'hC, 32'h0000_0000, 32'h0000_0000);
    presc_case(4'hA, 32'h0000_0001, 32'h0000_0002);
    presc_case(4'hB, 32'h0000_0000, 32'h0000_0001);
    $display("test prescaler done");
  endtask

  // Half mode matches on the low half only; calendar rolls seconds into minutes
  task automatic t_modes;
    int h;
    do_srst(32'h0000_0000);
    wr(rtcc_pkg::ADR_COMP, 32'hFFFF_0005);
    wr(rtcc_pkg::ADR_CTL_A, ctl(1'b1, 2'h1, 1'b1, 4'h1));
    poll(rtcc_pkg::ADR_BUSY, 32'h1 << rtcc_pkg::B_EN);
    h = hit_cnt;
    idle(200);
    rdw(rtcc_pkg::ADR_COUNT);
    check("half count held", 32'h1, {31'h0, rd <= 32'h5});
    check("half hit seen", 32'h1, {31'h0, hit_cnt > h});
    // Roughly 92 ticks at one per second: minute 1, seconds in range
    do_srst(32'h0000_0000);
    wr(rtcc_pkg::ADR_CTL_A, ctl(1'b1, 2'h2, 1'b0, 4'h1));
    poll(rtcc_pkg::ADR_BUSY, 32'h1 << rtcc_pkg::B_EN);
    idle(360);
    rdw(rtcc_pkg::ADR_COUNT);
    check("calendar minute", 32'h1, {26'h0, rd[11:6]});
    check("calendar second", 32'h1, {31'h0, rd[5:0] <= rtcc_pkg::CAL_MIN_SEC});
    $display("test modes done");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fields();
    t_match();
    t_soft_rst();
    t_presc();
    t_modes();
    print_verdict();
  end

endmodule // testbench
